// file: rtl/vout_slew_scale_floor_cmds.sv
// Slew rate, loop scale and floor command registers with output ramp
`timescale 1ns/1ps
module vout_slew_scale_floor_cmds (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Command port from the bus engine
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rd_valid_q,
  output logic [15:0] rd_data_q,
  // Nonvolatile restore and supply events
  input wire logic restore_pulse,
  input wire logic [15:0] nvm_slew,
  input wire logic [15:0] nvm_scale,
  input wire logic [15:0] nvm_floor,
  input wire logic supply_cycle_pulse,
  // Conversion context
  input wire logic conv_enable,
  input wire logic onoff_ramp,
  input wire logic [15:0] target_request,
  input wire logic [15:0] upper_limit,
  // Status
  input wire logic clear_faults,
  output logic invalid_data_q,
  output logic minmax_warn_q,
  output logic none_above_q,
  output logic word_vout_q,
  output logic alert_q,
  // Loop controls
  output logic [1:0] divider_sel_q,
  output logic [16:0] loop_scale_q,
  output logic [19:0] vref_fine_q
);
  // ****************
  // Decoding functions
  // ****************
  function automatic logic slew_ok(input logic [15:0] w);
    slew_ok = (w[15:11] == vout_cmd_pkg::SLEW_EXP_FIXED) &&
      (w[10:0] >= vout_cmd_pkg::SLEW_MANT_MIN) &&
      (w[10:0] <= vout_cmd_pkg::SLEW_MANT_MAX);
  endfunction
  function automatic logic [16:0] scale_val(input logic [15:0] w);
    logic signed [5:0] e;
    logic [27:0] v;
    e = 6'(signed'(w[15:11]));
    v = 28'h0000000;
    if (e >= -6'sd16 && e <= 6'sd0 && !w[10]) begin
      v = {17'h00000, w[10:0]} << 5'(e + 6'sd16);
    end
    if (v > {11'h000, vout_cmd_pkg::SCALE_ONE}) begin
      scale_val = 17'h00000;
    end else begin
      scale_val = v[16:0];
    end
  endfunction
  function automatic logic [1:0] divider_of(input logic [16:0] s);
    if (s <= vout_cmd_pkg::SCALE_EIGHTH) begin
      divider_of = vout_cmd_pkg::DIV_EIGHTH;
    end else if (s <= vout_cmd_pkg::SCALE_QUARTER) begin
      divider_of = vout_cmd_pkg::DIV_QUARTER;
    end else if (s <= vout_cmd_pkg::SCALE_HALF) begin
      divider_of = vout_cmd_pkg::DIV_HALF;
    end else begin
      divider_of = vout_cmd_pkg::DIV_ONE;
    end
  endfunction
  function automatic logic floor_ok(input logic [15:0] w);
    floor_ok = (w >= vout_cmd_pkg::LIMIT_LOW) &&
      (w <= vout_cmd_pkg::LIMIT_HIGH);
  endfunction

  // ****************
  // Command registers
  // ****************
  logic [15:0] slew_q;
  logic [15:0] scale_q;
  logic [15:0] floor_q;
  logic wr_slew, wr_scale, wr_floor, bad_write;
  always_comb begin
    wr_slew = 1'b0;
    wr_scale = 1'b0;
    wr_floor = 1'b0;
    bad_write = 1'b0;
    if (cmd_valid && cmd_write && cmd_code == vout_cmd_pkg::CMD_SLEW) begin
      wr_slew = slew_ok(cmd_wdata);
      bad_write = !slew_ok(cmd_wdata);
    end else if (cmd_valid && cmd_write &&
                 cmd_code == vout_cmd_pkg::CMD_SCALE) begin
      wr_scale = (scale_val(cmd_wdata) != 17'h00000);
      bad_write = (scale_val(cmd_wdata) == 17'h00000);
    end else if (cmd_valid && cmd_write &&
                 cmd_code == vout_cmd_pkg::CMD_FLOOR) begin
      wr_floor = floor_ok(cmd_wdata);
      bad_write = !floor_ok(cmd_wdata);
    end
  end
  // Stored words are kept verbatim so reads return what was written
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      slew_q <= {vout_cmd_pkg::SLEW_EXP_FIXED, vout_cmd_pkg::SLEW_MANT_RESET};
      scale_q <= {vout_cmd_pkg::SCALE_EXP_RESET,
                  vout_cmd_pkg::SCALE_MANT_RESET};
      floor_q <= vout_cmd_pkg::FLOOR_RESET;
    end else if (restore_pulse) begin
      slew_q <= nvm_slew;
      scale_q <= nvm_scale;
      floor_q <= nvm_floor;
    end else begin
      if (wr_slew) begin
        slew_q <= cmd_wdata;
      end
      if (wr_scale) begin
        scale_q <= cmd_wdata;
      end
      if (wr_floor) begin
        floor_q <= cmd_wdata;
      end
    end
  end

  // ****************
  // Read path
  // ****************
  // Codes owned by other blocks get no answer here
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      rd_valid_q <= 1'b0;
      if (cmd_valid && !cmd_write) begin
        if (cmd_code == vout_cmd_pkg::CMD_SLEW) begin
          rd_valid_q <= 1'b1;
          rd_data_q <= slew_q;
        end else if (cmd_code == vout_cmd_pkg::CMD_SCALE) begin
          rd_valid_q <= 1'b1;
          rd_data_q <= scale_q;
        end else if (cmd_code == vout_cmd_pkg::CMD_FLOOR) begin
          rd_valid_q <= 1'b1;
          rd_data_q <= floor_q;
        end
      end
    end
  end

  // ****************
  // Loop scale and divider
  // ****************
  logic scale_update;
  logic [15:0] scale_src;
  assign scale_update = !conv_enable || restore_pulse || supply_cycle_pulse;
  assign scale_src = restore_pulse ? nvm_scale : scale_q;
  // Divider tap cannot move under a live loop without glitching the output
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      loop_scale_q <= vout_cmd_pkg::SCALE_HALF;
      divider_sel_q <= vout_cmd_pkg::DIV_HALF;
    end else if (scale_update) begin
      loop_scale_q <= scale_val(scale_src);
      divider_sel_q <= divider_of(scale_val(scale_src));
    end
  end

  // ****************
  // Target limiting and warning
  // ****************
  logic below, above;
  logic [15:0] goal;
  assign below = target_request < floor_q;
  assign above = target_request > upper_limit;
  always_comb begin
    goal = target_request;
    if (below) begin
      goal = floor_q;
    end else if (above) begin
      goal = upper_limit;
    end
  end
  logic warn_evt;
  assign warn_evt = conv_enable && (below || above);
  // Set wins over clear so an event on the clear cycle is kept
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      minmax_warn_q <= 1'b0;
      none_above_q <= 1'b0;
      word_vout_q <= 1'b0;
      invalid_data_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      if (warn_evt) begin
        minmax_warn_q <= 1'b1;
        none_above_q <= 1'b1;
        word_vout_q <= 1'b1;
      end else if (clear_faults) begin
        minmax_warn_q <= 1'b0;
        none_above_q <= 1'b0;
        word_vout_q <= 1'b0;
      end
      if (bad_write) begin
        invalid_data_q <= 1'b1;
      end else if (clear_faults) begin
        invalid_data_q <= 1'b0;
      end
      if (warn_evt || bad_write) begin
        alert_q <= 1'b1;
      end else if (clear_faults) begin
        alert_q <= 1'b0;
      end
    end
  end

  // ****************
  // Slew timebase and ramp
  // ****************
  localparam logic [6:0] TICK_LAST = 7'(vout_cmd_pkg::TICK_CYCLES - 1);
  logic [6:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == TICK_LAST);
  always_ff @(posedge sys_clk) begin
    if (reset || tick) begin
      tick_cnt_q <= 7'h00;
    end else begin
      tick_cnt_q <= tick_cnt_q + 7'h01;
    end
  end
  // Every valid code is a supported slope at this step resolution
  logic [19:0] step, goal_fine, gap_up, gap_dn;
  assign step = {9'h000, slew_q[10:0]};
  assign goal_fine = {goal, 4'h0};
  assign gap_up = goal_fine - vref_fine_q;
  assign gap_dn = vref_fine_q - goal_fine;
  vout_cmd_pkg::ramp_state_t state_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= vout_cmd_pkg::RAMP_TRACK;
      vref_fine_q <= 20'h00000;
    end else begin
      case (state_q)
        vout_cmd_pkg::RAMP_TRACK: begin
          vref_fine_q <= goal_fine;
          if (conv_enable && !onoff_ramp) begin
            state_q <= vout_cmd_pkg::RAMP_HOLD;
          end
        end
        default: begin
          if (!conv_enable || onoff_ramp) begin
            vref_fine_q <= goal_fine;
            state_q <= vout_cmd_pkg::RAMP_TRACK;
          end else if (vref_fine_q < goal_fine) begin
            state_q <= vout_cmd_pkg::RAMP_UP;
            if (tick) begin
              vref_fine_q <= (gap_up <= step) ? goal_fine
                                              : vref_fine_q + step;
            end
          end else if (vref_fine_q > goal_fine) begin
            state_q <= vout_cmd_pkg::RAMP_DOWN;
            if (tick) begin
              vref_fine_q <= (gap_dn <= step) ? goal_fine
                                              : vref_fine_q - step;
            end
          end else begin
            state_q <= vout_cmd_pkg::RAMP_HOLD;
          end
        end
      endcase
    end
  end

  // ****************
  // Assertions
  // ****************
  logic [19:0] vref_prev_q, dref;
  always_ff @(posedge sys_clk) vref_prev_q <= vref_fine_q;
  assign dref = (vref_prev_q > vref_fine_q) ? vref_prev_q - vref_fine_q :
                vref_fine_q - vref_prev_q;
  property p_slew_step;
    @(posedge sys_clk) disable iff (reset)
      (state_q != vout_cmd_pkg::RAMP_TRACK && $past(state_q) !=
       vout_cmd_pkg::RAMP_TRACK && conv_enable && !onoff_ramp &&
       $stable(slew_q)) |-> (dref <= step);
  endproperty
  a_slew_step: assert property (p_slew_step)
    else $error("Reference moved more than one step");
  property p_bypass;
    @(posedge sys_clk) disable iff (reset)
      onoff_ramp |=> (vref_fine_q == $past(goal_fine));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("On/off ramp did not bypass slew");
  property p_tick_only;
    @(posedge sys_clk) disable iff (reset)
      (!tick && conv_enable && !onoff_ramp &&
       state_q != vout_cmd_pkg::RAMP_TRACK) |=> $stable(vref_fine_q);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("Reference moved without a tick");
  property p_slew_range;
    @(posedge sys_clk) disable iff (reset)
      (cmd_valid && cmd_write && cmd_code == vout_cmd_pkg::CMD_SLEW &&
       !restore_pulse && (cmd_wdata[10:0] < 11'h002 ||
       cmd_wdata[10:0] > 11'h0FE)) |=> ($stable(slew_q) && invalid_data_q
       && alert_q);
  endproperty
  a_slew_range: assert property (p_slew_range)
    else $error("Out of range slew was accepted");
  property p_scale_hold;
    @(posedge sys_clk) disable iff (reset)
      (conv_enable && !restore_pulse && !supply_cycle_pulse) |=>
        $stable(divider_sel_q);
  endproperty
  a_scale_hold: assert property (p_scale_hold)
    else $error("Divider changed while converting");
  property p_divider;
    @(posedge sys_clk) disable iff (reset)
      divider_sel_q == divider_of(loop_scale_q);
  endproperty
  a_divider: assert property (p_divider)
    else $error("Divider does not match scale");
  property p_readback;
    @(posedge sys_clk) disable iff (reset)
      (wr_scale && !restore_pulse) ##1 (cmd_valid && !cmd_write &&
       cmd_code == vout_cmd_pkg::CMD_SCALE && !restore_pulse) |=>
        (rd_valid_q && rd_data_q == $past(cmd_wdata, 2));
  endproperty
  a_readback: assert property (p_readback)
    else $error("Scale readback differs from write");
  property p_floor_warn;
    @(posedge sys_clk) disable iff (reset)
      (conv_enable && below) |=> (minmax_warn_q && none_above_q &&
       word_vout_q && alert_q);
  endproperty
  a_floor_warn: assert property (p_floor_warn)
    else $error("Floor violation did not warn");
  property p_floor_goal;
    @(posedge sys_clk) disable iff (reset)
      (conv_enable && !onoff_ramp && below) |-> goal == floor_q;
  endproperty
  a_floor_goal: assert property (p_floor_goal)
    else $error("Goal below floor");
  c_ramp_up: cover property (@(posedge sys_clk) disable iff (reset)
    state_q == vout_cmd_pkg::RAMP_UP ##1 state_q == vout_cmd_pkg::RAMP_HOLD);
  c_warn: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(minmax_warn_q));
  c_bad: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(invalid_data_q));
endmodule

// file: rtl/vout_cmd_pkg.sv
// Constants and types for the output slew, loop scale and floor commands
package vout_cmd_pkg;
  // ****************
  // Command codes
  // ****************
  localparam logic [7:0] CMD_SLEW = 8'h27;
  localparam logic [7:0] CMD_SCALE = 8'h29;
  localparam logic [7:0] CMD_FLOOR = 8'h2B;
  // ****************
  // Field layout of linear words
  // ****************
  localparam int EXP_LSB = 11;
  localparam int EXP_MSB = 15;
  localparam int MANT_MSB = 10;
  // ****************
  // Reset values and limits
  // ****************
  localparam logic [4:0] SLEW_EXP_FIXED = 5'h1C;
  localparam logic [10:0] SLEW_MANT_RESET = 11'h010;
  localparam logic [10:0] SLEW_MANT_MIN = 11'h002;
  localparam logic [10:0] SLEW_MANT_MAX = 11'h0FE;
  localparam logic [4:0] SCALE_EXP_RESET = 5'h19;
  localparam logic [10:0] SCALE_MANT_RESET = 11'h040;
  localparam logic [15:0] FLOOR_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_LOW = 16'h0000;
  localparam logic [15:0] LIMIT_HIGH = 16'hFFFF;
  // Loop scale in units of 2^-16
  localparam logic [16:0] SCALE_EIGHTH = 17'h02000;
  localparam logic [16:0] SCALE_QUARTER = 17'h04000;
  localparam logic [16:0] SCALE_HALF = 17'h08000;
  localparam logic [16:0] SCALE_ONE = 17'h10000;
  // ****************
  // Timing
  // ****************
  localparam int TICK_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  // ****************
  // Types
  // ****************
  typedef enum logic [1:0] {DIV_EIGHTH, DIV_QUARTER, DIV_HALF, DIV_ONE}
    divider_t;
  typedef enum {RAMP_TRACK, RAMP_HOLD, RAMP_UP, RAMP_DOWN} ramp_state_t;
endpackage

// file: test/host_model.sv
// Host model issuing word commands into the command port
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic sys_clk,
  // Command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rd_valid_q,
  input wire logic [15:0] rd_data_q
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // ****************
  // Word transfers
  // ****************
  // Strobe stands for the taking edge only
  task automatic issue(input logic wr, input logic [7:0] code,
                       input logic [15:0] data);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // Idle bus shows the inverse, never a stale word
    cmd_code <= ~code;
    cmd_wdata <= ~data;
  endtask
  task automatic write_word(input logic [7:0] code,
                            input logic [15:0] data);
    issue(1'b1, code, data);
  endtask
  // Write then read back to back, strobe held across both taking edges
  task automatic write_read(input logic [7:0] code, input logic [15:0] wd,
                            output logic [15:0] data, output logic got);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= wd;
    @(posedge sys_clk);
    cmd_write <= 1'b0;
    cmd_wdata <= ~wd;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~code;
    #1;
    got = rd_valid_q;
    data = rd_data_q;
  endtask
  // Answer is registered at the taking edge
  task automatic read_word(input logic [7:0] code,
                           output logic [15:0] data, output logic got);
    issue(1'b0, code, 16'h0000);
    #1;
    got = rd_valid_q;
    data = rd_data_q;
  endtask
endmodule

// file: test/vout_slew_scale_floor_cmds_bench.sv
// Self-checking bench for the slew, scale and floor command logic
`timescale 1ns/1ps
module vout_slew_scale_floor_cmds_bench;
  localparam logic [7:0] SLEW = vout_cmd_pkg::CMD_SLEW;
  localparam logic [7:0] SCALE = vout_cmd_pkg::CMD_SCALE;
  localparam logic [7:0] FLOOR = vout_cmd_pkg::CMD_FLOOR;
  // ****************
  // Design and host
  // ****************
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic restore_pulse = 1'b0;
  logic supply_cycle_pulse = 1'b0;
  logic conv_enable = 1'b0;
  logic onoff_ramp = 1'b0;
  logic clear_faults = 1'b0;
  logic [15:0] nvm_slew = 16'h0000;
  logic [15:0] nvm_scale = 16'h0000;
  logic [15:0] nvm_floor = 16'h0000;
  logic [15:0] target_request = 16'h0000;
  logic [15:0] upper_limit = 16'hFFFF;
  logic cmd_valid, cmd_write, rd_valid_q;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rd_data_q;
  logic invalid_data_q, minmax_warn_q, none_above_q, word_vout_q, alert_q;
  logic [1:0] divider_sel_q;
  logic [16:0] loop_scale_q;
  logic [19:0] vref_fine_q;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  vout_slew_scale_floor_cmds dut_u (.sys_clk, .reset, .cmd_valid,
    .cmd_write, .cmd_code, .cmd_wdata, .rd_valid_q, .rd_data_q,
    .restore_pulse, .nvm_slew, .nvm_scale, .nvm_floor,
    .supply_cycle_pulse, .conv_enable, .onoff_ramp, .target_request,
    .upper_limit, .clear_faults, .invalid_data_q, .minmax_warn_q,
    .none_above_q, .word_vout_q, .alert_q, .divider_sel_q,
    .loop_scale_q, .vref_fine_q);
  host_model host_u (.sys_clk, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_wdata, .rd_valid_q, .rd_data_q);
  // ****************
  // Checks
  // ****************
  task automatic check(input logic [19:0] got, input logic [19:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic flags(input logic [4:0] exp);
    check({invalid_data_q, minmax_warn_q, none_above_q, word_vout_q,
           alert_q}, exp, "status flags");
  endtask
  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic got;
    host_u.read_word(code, d, got);
    check(got, 1'b1, "read answer");
    check(d, exp, "read data");
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic clr();
    @(posedge sys_clk);
    clear_faults <= 1'b1;
    @(posedge sys_clk);
    clear_faults <= 1'b0;
  endtask
  // Bounded: a stuck ramp fails here, not at the timeout
  task automatic wait_vref(input logic [19:0] exp, input int lim);
    for (int i = 0; i < lim && vref_fine_q !== exp; i++) wait_cyc(1);
    check(vref_fine_q, exp, "settled reference");
  endtask
  // Any 100-cycle window in mid-ramp holds exactly one tick
  task automatic slope(input logic [19:0] step);
    logic [19:0] v0;
    wait_cyc(150);
    v0 = vref_fine_q;
    wait_cyc(100);
    check(vref_fine_q - v0, step, "step per tick");
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    rd_chk(SLEW, 16'hE010);
    rd_chk(SCALE, 16'hC840);
    rd_chk(FLOOR, 16'h0000);
    check(divider_sel_q, 2'h2, "divider");
    check(loop_scale_q, 17'h08000, "loop scale");
    check(vref_fine_q, 20'h00000, "reference");
    flags(5'h00);
  endtask
  task automatic t_slew();
    logic [15:0] bad [3] = '{16'hE001, 16'hE0FF, 16'h6010};
    host_u.write_word(SLEW, 16'hE002);
    rd_chk(SLEW, 16'hE002);
    host_u.write_word(SLEW, 16'hE0FE);
    rd_chk(SLEW, 16'hE0FE);
    flags(5'h00);
    foreach (bad[i]) begin
      clr();
      host_u.write_word(SLEW, bad[i]);
      rd_chk(SLEW, 16'hE0FE);
      flags(5'h11);
    end
  endtask
  task automatic t_scale();
    logic [10:0] m [6] = '{11'h010, 11'h011, 11'h020, 11'h021, 11'h041,
                           11'h080};
    logic [1:0] dv;
    logic [15:0] d;
    logic got;
    foreach (m[i]) begin
      dv = (m[i] <= 11'h010) ? 2'h0 : (m[i] <= 11'h020) ? 2'h1 :
           (m[i] <= 11'h040) ? 2'h2 : 2'h3;
      host_u.write_read(SCALE, {5'h19, m[i]}, d, got);
      check(got, 1'b1, "read answer");
      check(d, {5'h19, m[i]}, "read data");
      check(divider_sel_q, dv, "divider");
      check(loop_scale_q, {m[i][7:0], 9'h000}, "scale");
    end
    clr();
    host_u.write_word(SCALE, 16'hC881);
    host_u.write_word(SCALE, 16'hC800);
    rd_chk(SCALE, 16'hC880);
    flags(5'h11);
  endtask
  task automatic t_hold();
    @(posedge sys_clk);
    conv_enable <= 1'b1;
    host_u.write_word(SCALE, 16'hC810);
    rd_chk(SCALE, 16'hC810);
    check(loop_scale_q, 17'h10000, "held scale");
    @(posedge sys_clk);
    supply_cycle_pulse <= 1'b1;
    @(posedge sys_clk);
    supply_cycle_pulse <= 1'b0;
    wait_cyc(2);
    check(divider_sel_q, 2'h0, "divider");
    check(loop_scale_q, 17'h02000, "scale");
    @(posedge sys_clk);
    nvm_slew <= 16'hE020;
    nvm_scale <= 16'hC820;
    nvm_floor <= 16'h0000;
    restore_pulse <= 1'b1;
    @(posedge sys_clk);
    restore_pulse <= 1'b0;
    rd_chk(SLEW, 16'hE020);
    rd_chk(SCALE, 16'hC820);
    rd_chk(FLOOR, 16'h0000);
    check(loop_scale_q, 17'h04000, "restored scale");
    check(divider_sel_q, 2'h1, "restored divider");
  endtask
  task automatic t_ramp();
    @(posedge sys_clk);
    onoff_ramp <= 1'b1;
    target_request <= 16'd100;
    wait_cyc(2);
    check(vref_fine_q, 20'd1600, "on/off ramp");
    @(posedge sys_clk);
    onoff_ramp <= 1'b0;
    // Tracking ends on the edge after the one that drops the on/off ramp
    @(posedge sys_clk);
    target_request <= 16'd110;
    slope(20'd32);
    wait_vref(20'd1760, 1000);
  endtask
  task automatic t_floor();
    host_u.write_word(SLEW, 16'hE0A0);
    clr();
    host_u.write_word(FLOOR, 16'd200);
    wait_cyc(2);
    flags(5'h0F);
    slope(20'd160);
    wait_vref(20'd3200, 1200);
    host_u.write_word(FLOOR, 16'h0000);
    clr();
    wait_cyc(2);
    flags(5'h00);
    wait_vref(20'd1760, 1200);
    @(posedge sys_clk);
    upper_limit <= 16'd100;
    wait_cyc(2);
    flags(5'h0F);
    wait_vref(20'd1600, 300);
    @(posedge sys_clk);
    conv_enable <= 1'b0;
    clr();
    wait_cyc(2);
    flags(5'h00);
  endtask
  task automatic t_misc();
    logic [15:0] d;
    logic got;
    host_u.read_word(8'h24, d, got);
    check(got, 1'b0, "unmapped answer");
    host_u.write_word(FLOOR, 16'hFFFF);
    rd_chk(FLOOR, 16'hFFFF);
    flags(5'h00);
    check(vref_fine_q, 20'hFFFF0, "floor goal");
  endtask
  task automatic test_done();
    $display("Counts: %0d comparisons, %0d errors", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_slew();
    t_scale();
    t_hold();
    t_ramp();
    t_floor();
    t_misc();
    test_done();
  end
endmodule
